// File: verilog/tlmp_timer.sv
`timescale 1ns/10ps
`include "tlmp_regs.svh"
module tlmp_timer (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire tlmp_pkg::tlmp_req_t req,
   input wire tlmp_pkg::tlmp_cfg_t cfg,
   output logic [63:0] rd_data_ff,
   output logic rd_valid_ff,
   output logic [63:0] count_ff,
   output logic [1:0] match_irq_ff,
   output logic [1:0] pwm_out_ff
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] load_ff [2];
   logic [31:0] match_ff [2];
   logic [15:0] pre_ff [2];
   logic [15:0] pmatch_ff [2];
   logic [15:0] pcnt_ff [2];
   logic [31:0] cnt_ff [2];
   logic [31:0] nxt_load [2];
   logic [31:0] nxt_match [2];
   logic [15:0] nxt_pre [2];
   logic [15:0] nxt_pmatch [2];
   logic [15:0] nxt_pcnt [2];
   logic [31:0] nxt_cnt [2];
   logic [1:0] nxt_irq;
   logic [1:0] nxt_pwm;
   logic [63:0] nxt_rd_data;
   logic nxt_rd_valid;
   logic [1:0] hit;
   logic [31:0] wmask;
   logic [15:0] pmask;
   logic full64;
   logic [63:0] full_cnt;
   logic [63:0] full_nxt;
   logic [63:0] full_load;
   logic [63:0] full_match;
   logic [47:0] ext_cnt [2];
   logic [47:0] ext_match [2];
   logic [31:0] rval;

   always_comb begin
      wmask = cfg.variant64 ? 32'hffff_ffff : `TLMP_NARROW_MASK;
      pmask = cfg.variant64 ? 16'hffff : `TLMP_PRE_NARROW_MASK;
      full64 = cfg.full && cfg.variant64;
      full_load = full64 ? {load_ff[1], load_ff[0]} : {32'h0000_0000, load_ff[1][15:0], load_ff[0][15:0]};
      full_match = full64 ? {match_ff[1], match_ff[0]} : {32'h0000_0000, match_ff[1][15:0], match_ff[0][15:0]};
      full_cnt = full64 ? {cnt_ff[1], cnt_ff[0]} : {32'h0000_0000, cnt_ff[1][15:0], cnt_ff[0][15:0]};
      full_nxt = (full_cnt == 64'h0) ? full_load : full_cnt - 64'h1;
      for (int h = 0; h < 2; h++) begin
         ext_match[h] = {pmatch_ff[h], match_ff[h] & wmask};
         ext_cnt[h] = {pcnt_ff[h], cnt_ff[h] & wmask};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      for (int h = 0; h < 2; h++) begin
         nxt_load[h] = load_ff[h];
         nxt_match[h] = match_ff[h];
         nxt_pre[h] = pre_ff[h];
         nxt_pmatch[h] = pmatch_ff[h];
         nxt_pcnt[h] = pcnt_ff[h];
         nxt_cnt[h] = cnt_ff[h];
         hit[h] = 1'b0;
      end
      // Defaults come first, since half A's pass also sets half B's count in joined mode.
      for (int h = 0; h < 2; h++) begin
         if (cfg.full) begin
            if (h == 0 && cfg.run[0]) begin
               nxt_cnt[0] = full_nxt[31:0];
               nxt_cnt[1] = full_nxt[63:32];
               if (!full64) begin
                  nxt_cnt[0] = {16'h0000, full_nxt[15:0]};
                  nxt_cnt[1] = {16'h0000, full_nxt[31:16]};
               end
               hit[0] = (full_cnt == full_match);
            end
         end else if (cfg.run[h]) begin
            if (pcnt_ff[h] != 16'h0000) begin
               nxt_pcnt[h] = pcnt_ff[h] - 16'h0001;
            end else begin
               nxt_pcnt[h] = pre_ff[h];
               nxt_cnt[h] = ((cnt_ff[h] & wmask) == 32'h0) ? load_ff[h] : (cnt_ff[h] - 32'h1) & wmask;
            end
            hit[h] = (ext_cnt[h] == ext_match[h]);
         end
      end
      if (req.wr) begin
         for (int h = 0; h < 2; h++) begin
            if (req.sel == tlmp_pkg::TLMP_SEL_BOTH || (h == 0 && req.sel == tlmp_pkg::TLMP_SEL_A) ||
                (h == 1 && req.sel == tlmp_pkg::TLMP_SEL_B)) begin
               unique case (req.field)
                  tlmp_pkg::TLMP_F_LOAD: begin
                     nxt_load[h] = req.data[31:0] & wmask;
                     if (cfg.run[h]) begin
                        nxt_cnt[h] = req.data[31:0] & wmask;
                     end
                  end
                  tlmp_pkg::TLMP_F_MATCH: nxt_match[h] = req.data[31:0] & wmask;
                  tlmp_pkg::TLMP_F_PRE: nxt_pre[h] = req.data[15:0] & pmask;
                  tlmp_pkg::TLMP_F_PMATCH: nxt_pmatch[h] = req.data[15:0] & pmask;
               endcase
            end
         end
         if (req.wide && full64 && req.sel == tlmp_pkg::TLMP_SEL_A) begin
            if (req.field == tlmp_pkg::TLMP_F_LOAD) begin
               nxt_load[0] = req.data[31:0];
               nxt_load[1] = req.data[63:32];
               if (cfg.run[0]) begin
                  nxt_cnt[0] = req.data[31:0];
                  nxt_cnt[1] = req.data[63:32];
               end
            end else if (req.field == tlmp_pkg::TLMP_F_MATCH) begin
               nxt_match[0] = req.data[31:0];
               nxt_match[1] = req.data[63:32];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_irq = 2'b00;
      nxt_pwm = pwm_out_ff;
      for (int h = 0; h < 2; h++) begin
         if (cfg.mode == tlmp_pkg::TLMP_M_CAPCOUNT && hit[h]) begin
            nxt_irq[h] = 1'b1;
         end
         if (cfg.mode == tlmp_pkg::TLMP_M_PWM) begin
            nxt_pwm[h] = cfg.full ? (h == 0 && full_cnt > full_match) :
                         (ext_cnt[h] > ext_match[h]);
         end else begin
            nxt_pwm[h] = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      rval = 32'h0;
      unique case (req.field)
         tlmp_pkg::TLMP_F_LOAD: rval = (req.sel == tlmp_pkg::TLMP_SEL_B) ? load_ff[1] : load_ff[0];
         tlmp_pkg::TLMP_F_MATCH: rval = (req.sel == tlmp_pkg::TLMP_SEL_B) ? match_ff[1] : match_ff[0];
         tlmp_pkg::TLMP_F_PRE: rval = {16'h0000, (req.sel == tlmp_pkg::TLMP_SEL_B) ? pre_ff[1] : pre_ff[0]};
         tlmp_pkg::TLMP_F_PMATCH: rval = {16'h0000, (req.sel == tlmp_pkg::TLMP_SEL_B) ? pmatch_ff[1] : pmatch_ff[0]};
      endcase
      nxt_rd_data = {32'h0000_0000, rval};
      if (cfg.full && req.sel == tlmp_pkg::TLMP_SEL_A) begin
         if (req.field == tlmp_pkg::TLMP_F_LOAD) begin
            nxt_rd_data = full_load;
         end else if (req.field == tlmp_pkg::TLMP_F_MATCH) begin
            nxt_rd_data = full_match;
         end
      end
      nxt_rd_valid = req.rd;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         for (int h = 0; h < 2; h++) begin
            load_ff[h] <= `TLMP_LOAD_RST;
            match_ff[h] <= `TLMP_MATCH_RST;
            pre_ff[h] <= `TLMP_PRE_RST;
            pmatch_ff[h] <= `TLMP_PRE_RST;
            pcnt_ff[h] <= `TLMP_PRE_RST;
            cnt_ff[h] <= `TLMP_LOAD_RST;
         end
         match_irq_ff <= 2'b00;
         pwm_out_ff <= 2'b00;
         rd_data_ff <= 64'h0;
         rd_valid_ff <= 1'b0;
      end else begin
         for (int h = 0; h < 2; h++) begin
            load_ff[h] <= nxt_load[h];
            match_ff[h] <= nxt_match[h];
            pre_ff[h] <= nxt_pre[h];
            pmatch_ff[h] <= nxt_pmatch[h];
            pcnt_ff[h] <= nxt_pcnt[h];
            cnt_ff[h] <= nxt_cnt[h];
         end
         match_irq_ff <= nxt_irq;
         pwm_out_ff <= nxt_pwm;
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   assign count_ff = {cnt_ff[1], cnt_ff[0]};

   ////////////////////////////////////////////////////////////////////////
   sequence s_load_wr_a;
      req.wr && req.field == tlmp_pkg::TLMP_F_LOAD && req.sel != tlmp_pkg::TLMP_SEL_B && !req.wide && cfg.run[0];
   endsequence
   a_load_immediate: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_load_wr_a |=> cnt_ff[0] == ($past(req.data[31:0]) & wmask))
      else $error("Load write did not reach counter.");
   a_read_valid: assert property (@(posedge sys_clk) disable iff (!resetn)
      req.rd |=> rd_valid_ff)
      else $error("Read gave no answer.");
   a_capcount_irq: assert property (@(posedge sys_clk) disable iff (!resetn)
      cfg.mode != tlmp_pkg::TLMP_M_CAPCOUNT |=> match_irq_ff == 2'b00)
      else $error("Match irq outside capture count.");
   a_pwm_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
      cfg.mode != tlmp_pkg::TLMP_M_PWM |=> pwm_out_ff == 2'b00)
      else $error("Pwm output active outside pwm mode.");
   a_pre_bypass: assert property (@(posedge sys_clk) disable iff (!resetn)
      cfg.full && !req.wr |=> pcnt_ff[0] == $past(pcnt_ff[0]))
      else $error("Prescaler moved in full mode.");
   a_pre_range: assert property (@(posedge sys_clk) disable iff (!resetn)
      !cfg.variant64 && $stable(cfg.variant64) |=> pre_ff[0][15:8] == 8'h00 || $past(pre_ff[0][15:8]) != 8'h00)
      else $error("Prescale exceeds narrow range.");
   a_write_b_only: assert property (@(posedge sys_clk) disable iff (!resetn)
      req.wr && req.sel == tlmp_pkg::TLMP_SEL_B && req.field == tlmp_pkg::TLMP_F_MATCH
      |=> match_ff[0] == $past(match_ff[0]))
      else $error("Write to B changed A.");
   a_wide_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      req.wr && req.wide && full64 && req.sel == tlmp_pkg::TLMP_SEL_A && req.field == tlmp_pkg::TLMP_F_LOAD
      |=> {load_ff[1], load_ff[0]} == $past(req.data))
      else $error("Wide load not stored.");
endmodule : tlmp_timer

// File: verilog/tlmp_regs.svh
`ifndef TLMP_REGS_SVH
`define TLMP_REGS_SVH
`define TLMP_HALF_W 32
`define TLMP_FULL_W 64
`define TLMP_PRE_W 16
`define TLMP_PRE_W_NARROW 8
`define TLMP_LOAD_RST 32'h0000_0000
`define TLMP_MATCH_RST 32'h0000_0000
`define TLMP_PRE_RST 16'h0000
`define TLMP_PRE_NARROW_MASK 16'h00ff
`define TLMP_NARROW_MASK 32'h0000_ffff
`endif

// File: verilog/tlmp_pkg.sv
package tlmp_pkg;
   // Which value a software access names.
   typedef enum logic [1:0] {
      TLMP_F_LOAD,
      TLMP_F_MATCH,
      TLMP_F_PRE,
      TLMP_F_PMATCH
   } tlmp_field_t;
   // Target of a write; a read uses only the A and B codes.
   typedef enum logic [1:0] {
      TLMP_SEL_A,
      TLMP_SEL_B,
      TLMP_SEL_BOTH
   } tlmp_sel_t;
   // Counting style of the timer.
   typedef enum logic [1:0] {
      TLMP_M_PERIODIC,
      TLMP_M_CAPCOUNT,
      TLMP_M_PWM
   } tlmp_mode_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic wide;
      tlmp_field_t field;
      tlmp_sel_t sel;
      logic [63:0] data;
   } tlmp_req_t;
   typedef struct packed {
      logic full;
      logic variant64;
      tlmp_mode_t mode;
      logic [1:0] run;
   } tlmp_cfg_t;
endpackage : tlmp_pkg

// File: test/tlmp_timer_test.sv
`timescale 1ns/10ps
module tlmp_timer_test;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   tlmp_pkg::tlmp_req_t req = '0;
   tlmp_pkg::tlmp_cfg_t cfg = '0;
   logic [63:0] rd_data_ff;
   logic rd_valid_ff;
   logic [63:0] count_ff;
   logic [1:0] match_irq_ff;
   logic [1:0] pwm_out_ff;
   int num_errors = 0;
   int samples_checked = 0;
   int seed = 32'hd1f1;
   logic [63:0] got;
   logic [63:0] d;
   logic [31:0] c0;
   logic seen;
   int n;
   `define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); end end
   ////////////////////////////////////////////////////////////////////////////////
   always #20 sys_clk = ~sys_clk;
   tlmp_timer u_tlmp_timer (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .req(req),
      .cfg(cfg),
      .rd_data_ff(rd_data_ff),
      .rd_valid_ff(rd_valid_ff),
      .count_ff(count_ff),
      .match_irq_ff(match_irq_ff),
      .pwm_out_ff(pwm_out_ff)
   );
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] exp_half(input logic [63:0] v, input logic v64, input logic pre);
      if (pre) return v64 ? {16'h0000, v[15:0]} : {24'h000000, v[7:0]};
      return v64 ? v[31:0] : {16'h0000, v[15:0]};
   endfunction : exp_half
   task automatic wr_val(input tlmp_pkg::tlmp_field_t f, input tlmp_pkg::tlmp_sel_t s, input logic w,
                         input logic [63:0] v);
      @(posedge sys_clk);
      req <= '{wr: 1'b1, rd: 1'b0, wide: w, field: f, sel: s, data: v};
      @(posedge sys_clk);
      req.wr <= 1'b0;
      #1;
   endtask : wr_val
   task automatic rd_val(input tlmp_pkg::tlmp_field_t f, input tlmp_pkg::tlmp_sel_t s, input logic w);
      @(posedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b1, wide: w, field: f, sel: s, data: 64'h0};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1;
      `CHECK("rd_valid_ff", 1'b1, rd_valid_ff)
      got = rd_data_ff;
   endtask : rd_val
   task automatic set_cfg(input logic full, input logic v64, input tlmp_pkg::tlmp_mode_t m);
      @(posedge sys_clk);
      cfg <= '{full: full, variant64: v64, mode: m, run: 2'b11};
   endtask : set_cfg
   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      rd_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_A, 1'b0);
      `CHECK("load a after reset", 32'h0, got[31:0])
      for (int v = 0; v < 2; v++) begin
         set_cfg(1'b0, v[0], tlmp_pkg::TLMP_M_PERIODIC);
         for (int i = 0; i < 12; i++) begin
            d = {$random(seed), $random(seed)};
            wr_val(tlmp_pkg::tlmp_field_t'(i % 4), tlmp_pkg::tlmp_sel_t'(i % 3), 1'b0, d);
            if (i % 3 != 1) begin
               rd_val(tlmp_pkg::tlmp_field_t'(i % 4), tlmp_pkg::TLMP_SEL_A, 1'b0);
               `CHECK("half a value", exp_half(d, v[0], i % 4 > 1), got[31:0])
            end
            if (i % 3 != 0) begin
               rd_val(tlmp_pkg::tlmp_field_t'(i % 4), tlmp_pkg::TLMP_SEL_B, 1'b0);
               `CHECK("half b value", exp_half(d, v[0], i % 4 > 1), got[31:0])
            end
         end
      end
      // Reset again: random prescale values left the prescale counters mid-way through long cycles.
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      wr_val(tlmp_pkg::TLMP_F_PRE, tlmp_pkg::TLMP_SEL_BOTH, 1'b0, 64'h0);
      wr_val(tlmp_pkg::TLMP_F_PMATCH, tlmp_pkg::TLMP_SEL_BOTH, 1'b0, 64'h0);
      wr_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h5);
      `CHECK("count a reload", 32'h5, count_ff[31:0])
      wr_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_B, 1'b0, 64'h7a);
      `CHECK("count b reload", 32'h7a, count_ff[63:32])
      wr_val(tlmp_pkg::TLMP_F_PRE, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h3);
      wr_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h3e8);
      c0 = count_ff[31:0];
      repeat (40) @(posedge sys_clk);
      #1;
      n = c0 - count_ff[31:0];
      `CHECK("prescaled steps", 1'b1, (n >= 9 && n <= 11))
      // joined access through half A, prescaler ignored.
      set_cfg(1'b1, 1'b1, tlmp_pkg::TLMP_M_PERIODIC);
      d = 64'h0000_0001_0000_0100;
      wr_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_A, 1'b1, d);
      `CHECK("joined reload", d, count_ff)
      repeat (40) @(posedge sys_clk);
      #1;
      `CHECK("unscaled steps", 1'b1, (d - count_ff >= 39 && d - count_ff <= 41))
      rd_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_A, 1'b1);
      `CHECK("joined load", d, got)
      wr_val(tlmp_pkg::TLMP_F_MATCH, tlmp_pkg::TLMP_SEL_A, 1'b1, 64'hfedc_ba98_7654_3210);
      rd_val(tlmp_pkg::TLMP_F_MATCH, tlmp_pkg::TLMP_SEL_A, 1'b1);
      `CHECK("joined match", 64'hfedc_ba98_7654_3210, got)
      set_cfg(1'b0, 1'b1, tlmp_pkg::TLMP_M_CAPCOUNT);
      wr_val(tlmp_pkg::TLMP_F_PRE, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h0);
      wr_val(tlmp_pkg::TLMP_F_MATCH, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h14);
      wr_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h32);
      seen = 1'b0;
      for (int k = 0; k < 100 && !seen; k++) begin
         @(posedge sys_clk);
         #1;
         seen = (match_irq_ff[0] === 1'b1);
      end
      `CHECK("match event", 1'b1, seen)
      `CHECK("count at event", 1'b1, (count_ff[31:0] >= 32'h12 && count_ff[31:0] <= 32'h15))
      // duty follows match; the window spans two whole periods.
      set_cfg(1'b0, 1'b1, tlmp_pkg::TLMP_M_PWM);
      wr_val(tlmp_pkg::TLMP_F_MATCH, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'ha);
      wr_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h28);
      n = 0;
      repeat (82) begin
         @(posedge sys_clk);
         #1;
         n += (pwm_out_ff[0] === 1'b1);
      end
      `CHECK("pwm high cycles", 1'b1, (n >= 57 && n <= 63))
      set_cfg(1'b0, 1'b1, tlmp_pkg::TLMP_M_CAPCOUNT);
      wr_val(tlmp_pkg::TLMP_F_PRE, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h2);
      wr_val(tlmp_pkg::TLMP_F_PMATCH, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h1);
      wr_val(tlmp_pkg::TLMP_F_MATCH, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h14);
      wr_val(tlmp_pkg::TLMP_F_LOAD, tlmp_pkg::TLMP_SEL_A, 1'b0, 64'h32);
      seen = 1'b0;
      for (int k = 0; k < 200 && !seen; k++) begin
         @(posedge sys_clk);
         #1;
         seen = (match_irq_ff[0] === 1'b1);
      end
      `CHECK("extended match event", 1'b1, seen)
      `CHECK("count at extended event", 32'h14, count_ff[31:0])
      report_and_stop();
   end
endmodule : tlmp_timer_test
